// ### verilog/rtc_pkg.sv
// Package: register map, reset values and timing counts of the real-time counter
package rtc_pkg;
	// Register offsets (byte addresses on the 8-bit register port)
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_SYNC_STATUS = 4'h1;
	localparam logic [3:0] OFS_IRQ_CONTROL = 4'h2;
	localparam logic [3:0] OFS_IRQ_FLAGS = 4'h3;
	localparam logic [3:0] OFS_TEMP = 4'h4;
	localparam logic [3:0] OFS_CALIBRATION_SETTING = 4'h6;
	localparam logic [3:0] OFS_COUNT_LO = 4'h8;
	localparam logic [3:0] OFS_COUNT_HI = 4'h9;
	localparam logic [3:0] OFS_PERIOD_LO = 4'hA;
	localparam logic [3:0] OFS_PERIOD_HI = 4'hB;
	localparam logic [3:0] OFS_COMPARE_LO = 4'hC;
	localparam logic [3:0] OFS_COMPARE_HI = 4'hD;

	// Field positions
	localparam int CTRL_CORR_EN_BIT = 3;
	localparam int CTRL_PRESC_LSB = 0;
	localparam int IRQ_CMP_LVL_LSB = 2;
	localparam int IRQ_OVF_LVL_LSB = 0;
	localparam int FLAG_CMP_BIT = 1;
	localparam int FLAG_OVF_BIT = 0;
	localparam int CALIBRATION_SETTING_SIGN_BIT = 7;
	localparam int SYNC_BUSY_BIT = 0;

	// Reset values
	localparam logic [3:0] RST_CONTROL = 4'h0;
	localparam logic [3:0] RST_IRQ_CONTROL = 4'h0;
	localparam logic [7:0] RST_CALIBRATION_SETTING = 8'h00;
	localparam logic [7:0] RST_TEMP = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_PERIOD = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'h0000;

	// Timing counts, in counter reference clock edges
	localparam logic [1:0] SYNC_REF_EDGES = 2'h2;
	localparam int CORR_WINDOW_EDGES = 1048576;

	// Prescale select to divisor, indexed by select; zero means stopped
	localparam logic [10:0] PRESC_DIVISOR [8] = '{11'h000, 11'h001, 11'h002, 11'h008,
		11'h010, 11'h040, 11'h100, 11'h400};
endpackage

// ### verilog/rtc_counter.sv
// Real-time counter with prescaler, compare/period match and crystal correction
// Operation
// (R1) Keep a 16-bit count advancing on the prescaled clock, also during sleep.
// (R2) Divide the reference clock by a 10-bit prescaler before the counter.
// (R3) Select 000 stops; 001..111 divide by 1, 2, 8, 16, 64, 256, 1024.
// (R4) First increment after count equals compare raises compare request/event.
// (R5) First increment after count equals period raises overflow request/event.
// (R6) On overflow the count returns to zero instead of incrementing.
// (R7) Events on every third match for period 0, second for 1, all otherwise.
// (R8) Apply error-count single corrections spread over a one-million-edge window.
// (R9) Each correction inserts or skips exactly one prescaler input edge.
// (R10) Correction shows in the count that software reads.
// (R11) Enable starts correction; clearing stops it after the running window.
// (R12) Disabled mid-window, correction stays active until the window ends.
// (R13) Software must pick divide-by-two or more when correction speeds up.
// (R14) Count, control, period and compare writes act after a sync delay.
// (R15) Sync-busy reads one while such a write crosses, then clears itself.
// (R16) Compare level field enables compare interrupt; request while flag set.
// (R17) Overflow level field enables overflow interrupt; request while flag set.
// (R18) Compare flag sets after a match; clears on vector or written one.
// (R19) Compare and overflow requests can wake the system from sleep.
// (R20) Overflow flag sets after overflow; clears on vector or written one.
// (R21) Sign low slows the counter by adding edges; high removes edges.
// (R22) Compare above period never gives a compare request or event.
// (R23) Matches become single-cycle pulses in the system clock domain.
//
// Implementation choice: strobed register access.
module rtc_counter #(
	parameter int CORR_WINDOW = rtc_pkg::CORR_WINDOW_EDGES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Counter reference clock, asynchronous
	input wire logic rtcRefClk,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Interrupt controller
	input wire logic compareAck,
	input wire logic overflowAck,
	output logic [1:0] compareIrq,
	output logic [1:0] overflowIrq,
	output logic wakeRequest,
	// Event system
	output logic compareEvent,
	output logic overflowEvent
);
	localparam logic [20:0] WINDOW = 21'(CORR_WINDOW);

	logic refSync1, refSync2, refPrev;
	logic refEdge;
	logic [3:0] ctrlReg, ctrlEff;
	logic [3:0] irqCtrl;
	logic [7:0] calibration_setting;
	logic [7:0] temp;
	logic [15:0] cnt, period_value, cmp, perEff, cmpEff, cntStage;
	logic [3:0] pending;
	logic [1:0] syncEdges;
	logic applySync;
	logic [10:0] pre;
	logic [10:0] divisor;
	logic [10:0] preSum;
	logic cntTick;
	logic corrActive;
	logic [20:0] winCnt, acc, accSum;
	logic corrFire;
	logic insertEdge, skipEdge;
	logic cmpMatch, ovfMatch;
	logic [1:0] cmpEvtDiv, ovfEvtDiv;
	logic [1:0] evtLimit;
	logic cmpFlag, ovfFlag;
	logic wrLo, wrHi;

	// Reference clock is a pin to this domain: two flops, then edge detect
	always_ff @(posedge clk) begin
		if (rst) begin
			refSync1 <= 1'b0;
			refSync2 <= 1'b0;
			refPrev <= 1'b0;
		end else begin
			refSync1 <= rtcRefClk;
			refSync2 <= refSync1;
			refPrev <= refSync2;
		end
	end
	assign refEdge = refSync2 & ~refPrev;

	// Register writes that need no domain crossing
	always_ff @(posedge clk) begin
		if (rst) begin
			irqCtrl <= rtc_pkg::RST_IRQ_CONTROL;
			calibration_setting <= rtc_pkg::RST_CALIBRATION_SETTING;
		end else if (regWrite) begin
			if (regAddr == rtc_pkg::OFS_IRQ_CONTROL)
				irqCtrl <= regWrData[3:0];
			if (regAddr == rtc_pkg::OFS_CALIBRATION_SETTING)
				calibration_setting <= regWrData;
		end
	end

	// Low byte of a 16-bit write waits in temp; high byte write commits
	assign wrLo = regWrite && (regAddr == rtc_pkg::OFS_COUNT_LO
		|| regAddr == rtc_pkg::OFS_PERIOD_LO || regAddr == rtc_pkg::OFS_COMPARE_LO
		|| regAddr == rtc_pkg::OFS_TEMP);
	assign wrHi = regWrite && (regAddr == rtc_pkg::OFS_COUNT_HI
		|| regAddr == rtc_pkg::OFS_PERIOD_HI || regAddr == rtc_pkg::OFS_COMPARE_HI);

	always_ff @(posedge clk) begin
		if (rst) begin
			temp <= rtc_pkg::RST_TEMP;
		end else if (wrLo) begin
			temp <= regWrData;
		end else if (regRead) begin
			// Reading a low byte freezes its high byte for the next read
			unique case (regAddr)
				rtc_pkg::OFS_COUNT_LO: temp <= cnt[15:8];
				rtc_pkg::OFS_PERIOD_LO: temp <= period_value[15:8];
				rtc_pkg::OFS_COMPARE_LO: temp <= cmp[15:8];
				default: temp <= temp;
			endcase
		end
	end

	// Staged values and pending mask: cnt, ctrl, per, cmp
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlReg <= rtc_pkg::RST_CONTROL;
			period_value <= rtc_pkg::RST_PERIOD;
			cmp <= rtc_pkg::RST_COMPARE;
			cntStage <= rtc_pkg::RST_COUNT;
			pending <= 4'h0;
		end else begin
			if (applySync)
				pending <= 4'h0;
			if (regWrite) begin
				unique case (regAddr)
					rtc_pkg::OFS_CONTROL: begin
						ctrlReg <= regWrData[3:0];
						pending[1] <= 1'b1; // R14
					end
					rtc_pkg::OFS_COUNT_HI: begin
						cntStage <= {regWrData, temp};
						pending[0] <= 1'b1; // R14
					end
					rtc_pkg::OFS_PERIOD_HI: begin
						period_value <= {regWrData, temp};
						pending[2] <= 1'b1; // R14
					end
					rtc_pkg::OFS_COMPARE_HI: begin
						cmp <= {regWrData, temp};
						pending[3] <= 1'b1; // R14
					end
					default: pending <= applySync ? 4'h0 : pending;
				endcase
			end
		end
	end

	// Crossing takes a fixed number of reference edges; a new write restarts it
	always_ff @(posedge clk) begin
		if (rst) begin
			syncEdges <= 2'h0;
		end else if (regWrite && (wrHi || regAddr == rtc_pkg::OFS_CONTROL)) begin
			syncEdges <= 2'h0;
		end else if (|pending && refEdge) begin
			syncEdges <= applySync ? 2'h0 : syncEdges + 2'h1; // R14
		end
	end
	assign applySync = |pending && refEdge && (syncEdges == rtc_pkg::SYNC_REF_EDGES - 2'h1)
		&& !(regWrite && (wrHi || regAddr == rtc_pkg::OFS_CONTROL));

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlEff <= rtc_pkg::RST_CONTROL;
			perEff <= rtc_pkg::RST_PERIOD;
			cmpEff <= rtc_pkg::RST_COMPARE;
		end else if (applySync) begin
			if (pending[1])
				ctrlEff <= ctrlReg; // R14
			if (pending[2])
				perEff <= period_value;
			if (pending[3])
				cmpEff <= cmp;
		end
	end

	// Correction scheduler: accumulate error each edge, fire on window overflow
	assign accSum = acc + {14'h0000, calibration_setting[6:0]};
	assign corrFire = corrActive && refEdge && (accSum >= WINDOW); // R8
	assign insertEdge = corrFire && !calibration_setting[rtc_pkg::CALIBRATION_SETTING_SIGN_BIT]; // R21
	assign skipEdge = corrFire && calibration_setting[rtc_pkg::CALIBRATION_SETTING_SIGN_BIT]; // R21

	always_ff @(posedge clk) begin
		if (rst) begin
			corrActive <= 1'b0;
			winCnt <= 21'h000000;
			acc <= 21'h000000;
		end else if (!corrActive) begin
			winCnt <= 21'h000000;
			acc <= 21'h000000;
			corrActive <= ctrlEff[rtc_pkg::CTRL_CORR_EN_BIT]; // R11
		end else if (refEdge) begin
			acc <= corrFire ? accSum - WINDOW : accSum; // R8
			if (winCnt == WINDOW - 21'h000001) begin
				winCnt <= 21'h000000;
				// Disable only lands on a window boundary
				corrActive <= ctrlEff[rtc_pkg::CTRL_CORR_EN_BIT]; // R12
			end else begin
				winCnt <= winCnt + 21'h000001;
			end
		end
	end

	// Prescaler: step 0 inserts an edge, step 2 skips one; skip needs divisor two or more
	assign divisor = rtc_pkg::PRESC_DIVISOR[ctrlEff[2:0]]; // R3
	assign preSum = pre + (insertEdge ? 11'h000 : skipEdge ? 11'h002 : 11'h001); // R9
	assign cntTick = refEdge && (divisor != 11'h000) && (preSum >= divisor); // R2

	always_ff @(posedge clk) begin
		if (rst) begin
			pre <= 11'h000;
		end else if (divisor == 11'h000) begin
			pre <= 11'h000; // R3
		end else if (refEdge) begin
			pre <= cntTick ? preSum - divisor : preSum; // R13
		end
	end

	// Matches use the value present before the increment
	assign ovfMatch = cntTick && (cnt == perEff); // R5
	assign cmpMatch = cntTick && (cnt == cmpEff) && (cmpEff <= perEff); // R4 R22

	// Count steps on reference-clock edges regardless of sleep; no sleep gating here
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= rtc_pkg::RST_COUNT;
		end else if (applySync && pending[0]) begin
			cnt <= cntStage; // R14
		end else if (ovfMatch) begin
			cnt <= 16'h0000; // R6
		end else if (cntTick) begin
			cnt <= cnt + 16'h0001; // R1 R10
		end
	end

	// Sync-limited event rate for tiny periods
	assign evtLimit = (perEff == 16'h0000) ? 2'h2 : (perEff == 16'h0001) ? 2'h1 : 2'h0;

	always_ff @(posedge clk) begin
		if (rst) begin
			cmpEvtDiv <= 2'h0;
			ovfEvtDiv <= 2'h0;
			compareEvent <= 1'b0;
			overflowEvent <= 1'b0;
		end else begin
			// One-cycle pulses in this domain
			compareEvent <= cmpMatch && (cmpEvtDiv >= evtLimit); // R7 R23
			overflowEvent <= ovfMatch && (ovfEvtDiv >= evtLimit); // R7 R23
			if (cmpMatch)
				cmpEvtDiv <= (cmpEvtDiv >= evtLimit) ? 2'h0 : cmpEvtDiv + 2'h1;
			if (ovfMatch)
				ovfEvtDiv <= (ovfEvtDiv >= evtLimit) ? 2'h0 : ovfEvtDiv + 2'h1;
		end
	end

	// Flags: a match in the clearing cycle keeps the flag set
	always_ff @(posedge clk) begin
		if (rst) begin
			cmpFlag <= 1'b0;
		end else if (cmpMatch) begin
			cmpFlag <= 1'b1; // R18 R23
		end else if (compareAck || (regWrite && regAddr == rtc_pkg::OFS_IRQ_FLAGS
			&& regWrData[rtc_pkg::FLAG_CMP_BIT])) begin
			cmpFlag <= 1'b0; // R18
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ovfFlag <= 1'b0;
		end else if (ovfMatch) begin
			ovfFlag <= 1'b1; // R20 R23
		end else if (overflowAck || (regWrite && regAddr == rtc_pkg::OFS_IRQ_FLAGS
			&& regWrData[rtc_pkg::FLAG_OVF_BIT])) begin
			ovfFlag <= 1'b0; // R20
		end
	end

	// Requests carry their level; level zero means disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			compareIrq <= 2'h0;
			overflowIrq <= 2'h0;
			wakeRequest <= 1'b0;
		end else begin
			compareIrq <= cmpFlag ? irqCtrl[rtc_pkg::IRQ_CMP_LVL_LSB +: 2] : 2'h0; // R16
			overflowIrq <= ovfFlag ? irqCtrl[rtc_pkg::IRQ_OVF_LVL_LSB +: 2] : 2'h0; // R17
			wakeRequest <= (cmpFlag && irqCtrl[rtc_pkg::IRQ_CMP_LVL_LSB +: 2] != 2'h0)
				|| (ovfFlag && irqCtrl[rtc_pkg::IRQ_OVF_LVL_LSB +: 2] != 2'h0); // R19
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (rst || !regRead) begin
			regRdData <= 8'h00;
		end else begin
			unique case (regAddr)
				rtc_pkg::OFS_CONTROL: regRdData <= {4'h0, ctrlReg};
				rtc_pkg::OFS_SYNC_STATUS: regRdData <= {7'h00, |pending}; // R15
				rtc_pkg::OFS_IRQ_CONTROL: regRdData <= {4'h0, irqCtrl};
				rtc_pkg::OFS_IRQ_FLAGS: regRdData <= {6'h00, cmpFlag, ovfFlag};
				rtc_pkg::OFS_TEMP: regRdData <= temp;
				rtc_pkg::OFS_CALIBRATION_SETTING: regRdData <= calibration_setting;
				rtc_pkg::OFS_COUNT_LO: regRdData <= cnt[7:0]; // R10
				rtc_pkg::OFS_PERIOD_LO: regRdData <= period_value[7:0];
				rtc_pkg::OFS_COMPARE_LO: regRdData <= cmp[7:0];
				rtc_pkg::OFS_COUNT_HI, rtc_pkg::OFS_PERIOD_HI, rtc_pkg::OFS_COMPARE_HI:
					regRdData <= temp;
				default: regRdData <= 8'h00;
			endcase
		end
	end
endmodule

// ### sim/rtc_counter_asserts.sv
// Port checker of the real-time counter
module rtc_counter_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Interrupts and events
	input wire logic compareAck,
	input wire logic [1:0] compareIrq,
	input wire logic [1:0] overflowIrq,
	input wire logic wakeRequest,
	input wire logic compareEvent,
	input wire logic overflowEvent
);
	logic [1:0] cmpLvl;
	logic [1:0] ovfLvl;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Level fields act at once, so mirror them on the write
	always_ff @(posedge clk) begin
		if (rst) begin
			cmpLvl <= 2'h0;
			ovfLvl <= 2'h0;
		end else if (regWrite && regAddr == 4'h2) begin
			cmpLvl <= regWrData[3:2];
			ovfLvl <= regWrData[1:0];
		end
	end
	chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside answer cycle");
	chk_rd_unmapped: assert property (regRead && (regAddr == 4'h5 || regAddr == 4'h7
		|| regAddr > 4'hD) |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_status_rsvd: assert property (regRead && regAddr == 4'h1 |=> regRdData[7:1] == 7'h00)
		else $error("status reserved bits set");
	chk_busy_set: assert property (regWrite && regAddr == 4'h0 ##1 regRead && regAddr == 4'h1
		|=> regRdData[0])
		else $error("busy not shown after control write");
	chk_cmp_level: assert property (compareIrq != 2'h0 |-> compareIrq == $past(cmpLvl))
		else $error("compare request level wrong");
	chk_ovf_level: assert property (overflowIrq != 2'h0 |-> overflowIrq == $past(ovfLvl))
		else $error("overflow request level wrong");
	chk_wake_req: assert property (compareIrq != 2'h0 || overflowIrq != 2'h0
		|-> ##[0:1] wakeRequest)
		else $error("no wake with pending request");
	chk_cmp_pulse: assert property (compareEvent |=> !compareEvent)
		else $error("compare event longer than a cycle");
	chk_ovf_pulse: assert property ($rose(overflowEvent) |=> $fell(overflowEvent))
		else $error("overflow event longer than a cycle");
	cover property (overflowEvent);
	cover property (compareEvent);
	cover property (compareAck ##[1:4] compareIrq == 2'h0);
endmodule
bind rtc_counter rtc_counter_asserts u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.compareAck(compareAck), .compareIrq(compareIrq), .overflowIrq(overflowIrq),
	.wakeRequest(wakeRequest), .compareEvent(compareEvent), .overflowEvent(overflowEvent));

// ### sim/rtc_irq_ctrl_model.sv
// Interrupt controller model that runs the vector of a pending request
module rtc_irq_ctrl_model #(
	parameter int DELAY = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ackEn,
	input wire logic [1:0] irq,
	output logic ack = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int waitCnt = 0;
	// One vector per request; re-arms only once the request drops
	always @(posedge clk) begin
		ack <= !rst && ackEn && irq != 2'h0 && waitCnt == DELAY;
		waitCnt <= (rst || !ackEn || irq == 2'h0) ? 0 : (waitCnt > DELAY ? waitCnt : waitCnt + 1);
	end
endmodule

// ### sim/rtc_counter_tb.sv
// Self-checking bench of the real-time counter
module rtc_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, rtcRefClk = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00, regRdData, r;
	logic compareAck, overflowAck, wakeRequest, compareEvent, overflowEvent;
	logic ackEn = 1'b0, rdLate = 1'b0;
	logic [1:0] compareIrq, overflowIrq, refDiv = 2'h0;
	logic [15:0] refN = 16'h0000, lastEv = 16'h0000, cmpN = 16'h0000, lastCmp = 16'h0000, c;
	logic [15:0] rdQ[$], evQ[$], cmpQ[$];
	int err_count = 0, comparisons = 0;
	// ctrl, period, compare, calibration_setting, edges per overflow event, compare events per interval
	logic [71:0] tbl [11] = '{72'h01_0000_0000_00_0003_FF, 72'h01_0001_0000_00_0004_FF,
		72'h01_0002_0040_00_0003_00, 72'h02_0002_0001_00_0006_01, 72'h03_0002_0001_00_0018_01,
		72'h04_0002_0001_00_0030_01, 72'h05_0002_0001_00_00C0_01, 72'h06_0002_0001_00_0300_01,
		72'h07_0002_0001_00_0C00_01, 72'h0A_0021_0001_84_0040_01, 72'h09_003B_0001_04_0040_01};
	rtc_counter #(.CORR_WINDOW(64)) u_dut (.clk(clk), .rst(rst), .rtcRefClk(rtcRefClk),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .compareAck(compareAck), .overflowAck(overflowAck),
		.compareIrq(compareIrq), .overflowIrq(overflowIrq), .wakeRequest(wakeRequest),
		.compareEvent(compareEvent), .overflowEvent(overflowEvent));
	// Prompt and slow controllers
	rtc_irq_ctrl_model #(.DELAY(1)) u_cmpCtl (.clk(clk), .rst(rst), .ackEn(ackEn),
		.irq(compareIrq), .ack(compareAck));
	rtc_irq_ctrl_model #(.DELAY(6)) u_ovfCtl (.clk(clk), .rst(rst), .ackEn(ackEn),
		.irq(overflowIrq), .ack(overflowAck));
	initial forever #5 clk = ~clk;
	// Reference clock of 8 clk periods, so every event lands before the next edge
	always @(posedge clk) begin
		refDiv <= refDiv + 2'h1;
		if (refDiv == 2'h3) rtcRefClk <= ~rtcRefClk;
		if (refDiv == 2'h3 && !rtcRefClk) refN <= refN + 16'h1;
	end
	always @(posedge clk) begin
		rdLate <= regRead;
		if (rdLate) check(16'(regRdData), rdQ.pop_front());
		if (compareEvent) cmpN <= cmpN + 16'h1;
		if (overflowEvent) begin
			lastEv <= refN;
			lastCmp <= cmpN;
			if (evQ.size() > 0) begin
				check(refN - lastEv, evQ.pop_front());
				c = cmpQ.pop_front();
				if (c != 16'h00FF) check(cmpN - lastCmp, c);
			end
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= w;
		regRead <= !w;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rdQ.push_back({8'h00, e});
		acc(1'b0, a, 8'h00);
	endtask
	task automatic idle(input int n);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	// Waits for an overflow event, or for n reference edges
	task automatic waitFor(input logic ovf, input int n);
		int i;
		logic [15:0] base;
		i = 0;
		base = refN;
		do begin
			@(posedge clk);
			i++;
		end while ((ovf ? overflowEvent !== 1'b1 : refN - base != 16'(n)) && i < 60000);
		if (i >= 60000) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic cfg(input logic [71:0] t);
		acc(1'b1, 4'h6, t[31:24]);
		acc(1'b1, 4'hA, t[55:48]);
		acc(1'b1, 4'hB, t[63:56]);
		acc(1'b1, 4'hC, t[39:32]);
		acc(1'b1, 4'hD, t[47:40]);
		acc(1'b1, 4'h0, t[71:64]);
		rd(4'h1, 8'h01);
		idle(1);
		waitFor(1'b0, 3);
		rd(4'h1, 8'h00);
		idle(1);
	endtask
	initial begin
		void'($urandom(42));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
		r = 8'($urandom) | 8'h05;
		acc(1'b1, 4'h2, r);
		rd(4'h2, {4'h0, r[3:0]});
		r = 8'($urandom);
		acc(1'b1, 4'h4, r);
		rd(4'h4, r);
		ackEn <= 1'b1;
		foreach (tbl[k]) begin
			cfg(tbl[k]);
			waitFor(1'b1, 0);
			idle(1);
			evQ.push_back(tbl[k][23:8]);
			cmpQ.push_back({8'h00, tbl[k][7:0]});
			waitFor(1'b1, 0);
		end
		ackEn <= 1'b0;
		cfg(72'h01_0010_0005_00_0000_00);
		waitFor(1'b1, 0);
		waitFor(1'b0, 5);
		idle(6);
		rd(4'h8, 8'h05);
		rd(4'h9, 8'h00);
		idle(1);
		waitFor(1'b0, 2);
		idle(6);
		rd(4'h3, 8'h03);
		acc(1'b1, 4'h3, 8'h02);
		rd(4'h3, 8'h01);
		acc(1'b1, 4'h0, 8'h00);
		idle(1);
		waitFor(1'b0, 3);
		acc(1'b1, 4'h3, 8'h03);
		rd(4'h3, 8'h00);
		idle(1);
		waitFor(1'b0, 20);
		rd(4'h3, 8'h00);
		idle(2);
		summarize();
	end
endmodule
